// [design/i2c_eeprom_write_control.sv]
// Two-wire EEPROM target: framing, addressing, page write, programming, reads
`include "eeprom_defs.svh"

module i2c_eeprom_write_control #(
	parameter int unsigned WRITE_CYCLE_CYCLES =
		(`WRITE_CYCLE_TIME_US * 1000) / `CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic wp,
	output logic standby,
	output logic prog_busy
);

	localparam int unsigned TIMER_W = $clog2(WRITE_CYCLE_CYCLES + 1);
	// The timer doubles as the column index while a page is committed, so
	// a cycle count below the page size would leave loaded columns unwritten

	// Link side: bytes are gathered on the serial clock itself
	// Only the serial clock meets the data setup window; the local clock sees
	// the pins late through the synchronisers and merely counts the edges
	logic [7:0] rx_byte;

	scl_shift_in u_shift (
		.scl(scl),
		.rst_n(rst_n),
		.sda_i(sda_i),
		.shift_q(rx_byte)
	);

	// Pin levels into the local domain
	eeprom_pkg::pins_t pins_raw;
	eeprom_pkg::pins_t pins_s;
	logic [2:0] pins_raw_v;
	logic [2:0] pins_s_v;
	// Clock and data idle high, protect idles low
	localparam logic [2:0] PIN_IDLE = `PIN_IDLE;

	assign pins_raw.scl = scl;
	assign pins_raw.sda = sda_i;
	assign pins_raw.wp = wp;
	assign pins_raw_v = pins_raw;
	assign pins_s = pins_s_v;

	// One synchroniser per pin, each reset to its pin's idle level
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			sync_2ff #(
				.RESET_VAL(PIN_IDLE[g])
			) u_sync (
				.clk(clk),
				.rst_n(rst_n),
				.d(pins_raw_v[g]),
				.q(pins_s_v[g])
			);
		end
	endgenerate

	// Previous levels reset high too, so no false edge follows reset
	logic scl_p_q;
	logic sda_p_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= pins_s.scl;
			sda_p_q <= pins_s.sda;
		end
	end

	// Bus events
	wire scl_rise = pins_s.scl & ~scl_p_q;
	wire scl_fall = ~pins_s.scl & scl_p_q;
	wire scl_held = pins_s.scl & scl_p_q;
	wire start_ev = scl_held & sda_p_q & ~pins_s.sda;
	wire stop_ev = scl_held & ~sda_p_q & pins_s.sda;

	// Address-counter helpers
	function automatic logic [`ADDR_W-1:0] addr_inc(input logic [`ADDR_W-1:0] a);
		addr_inc = a + `ADDR_W'(1);
	endfunction

	function automatic logic [`ADDR_W-1:0] col_inc(input logic [`ADDR_W-1:0] a);
		col_inc = {a[`ADDR_W-1:`COL_W], a[`COL_W-1:0] + `COL_W'(1)};
	endfunction

	// Open drain: a zero is shown by pulling the line, a one by letting go
	function automatic logic pull_for(input logic [7:0] b, input logic [2:0] i);
		pull_for = ~b[i];
	endfunction

	// Storage
	logic [7:0] mem [0:`MEM_DEPTH-1];
	logic [7:0] page_buf [0:`PAGE_BYTES-1];

	// State
	eeprom_pkg::state_t state_q, state_d;
	logic [3:0] bit_q, bit_d;
	logic oe_q, oe_d;
	logic rw_q, rw_d;
	logic nack_q, nack_d;
	logic wrote_q, wrote_d;
	logic [2:0] dev_hi_q, dev_hi_d;
	logic [`ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] tx_q, tx_d;
	logic [`PAGE_BYTES-1:0] mask_q, mask_d;
	logic [TIMER_W-1:0] timer_q, timer_d;
	logic standby_q;
	logic busy_q;

	// Decodes
	// Combinational array read: the first bit is ready at the acknowledge fall
	wire [7:0] mem_rd = mem[addr_q];
	wire [`COL_W-1:0] col = addr_q[`COL_W-1:0];
	wire [`COL_W-1:0] prog_col = timer_q[`COL_W-1:0];
	wire at_last_data = (bit_q == `BIT_LAST_DATA);
	wire at_ack = (bit_q == `BIT_ACK);
	// Only the type nibble is compared; the three address bits ride along
	wire dev_match = (rx_byte[7:4] == `DEV_TYPE_CODE);
	wire timer_done = (timer_q == TIMER_W'(WRITE_CYCLE_CYCLES - 1));
	wire prog_phase = (timer_q < TIMER_W'(`PAGE_BYTES));
	// State decodes shared by the transfer logic and the status flags
	wire in_wdata = (state_q == eeprom_pkg::ST_WDATA);
	wire in_rdata = (state_q == eeprom_pkg::ST_RDATA);
	wire in_busy = (state_q == eeprom_pkg::ST_BUSY);
	wire next_idle = (state_d == eeprom_pkg::ST_IDLE);
	wire next_busy = (state_d == eeprom_pkg::ST_BUSY);
	wire buf_we = scl_fall & at_last_data & in_wdata;
	wire mem_we = in_busy & prog_phase & mask_q[prog_col];
	wire [2:0] tx_sel = 3'(7 - bit_q);

	// rx_byte changes only on a rising serial clock; it is read only at the
	// synchronised falling edge after the eighth bit, when it has been stable
	// for the whole high phase and stays so until the next rise.
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		oe_d = oe_q;
		rw_d = rw_q;
		nack_d = nack_q;
		wrote_d = wrote_q;
		dev_hi_d = dev_hi_q;
		addr_d = addr_q;
		tx_d = tx_q;
		mask_d = mask_q;
		timer_d = timer_q;
		if (in_busy) begin
			// Pins are not looked at until programming has run its time
			timer_d = timer_q + TIMER_W'(1);
			if (timer_done) begin
				state_d = eeprom_pkg::ST_IDLE;
				timer_d = '0;
			end
		end else if (start_ev) begin
			// A repeated START after the word address keeps the counter
			state_d = eeprom_pkg::ST_DEV;
			bit_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_ev) begin
			bit_d = 4'h0;
			oe_d = 1'b0;
			// Protect is looked at only here; protected bytes were still acknowledged
			if (in_wdata && wrote_q && !pins_s.wp) begin
				state_d = eeprom_pkg::ST_BUSY;
				timer_d = '0;
			end else begin
				state_d = eeprom_pkg::ST_IDLE;
			end
		end else if (state_q != eeprom_pkg::ST_IDLE) begin
			if (scl_rise) begin
				bit_d = bit_q + 4'h1;
				if (in_rdata && at_last_data) begin
					// Controller's answer at the ninth rise of a read byte
					nack_d = pins_s.sda;
				end
			end else if (scl_fall) begin
				// All drive changes happen here, with the clock low, except the release at START and STOP
				case (state_q)
					eeprom_pkg::ST_DEV: begin
						if (at_last_data) begin
							if (dev_match) begin
								oe_d = 1'b1;
								rw_d = rx_byte[0];
								dev_hi_d = rx_byte[3:1];
							end else begin
								// Withholding the acknowledge just leaves the line released
								state_d = eeprom_pkg::ST_IDLE;
								bit_d = 4'h0;
							end
						end else if (at_ack) begin
							bit_d = 4'h0;
							if (rw_q) begin
								state_d = eeprom_pkg::ST_RDATA;
								tx_d = mem_rd;
								addr_d = addr_inc(addr_q);
								oe_d = pull_for(mem_rd, 3'h7);
							end else begin
								state_d = eeprom_pkg::ST_WADDR;
								oe_d = 1'b0;
							end
						end
					end
					eeprom_pkg::ST_WADDR: begin
						if (at_last_data) begin
							oe_d = 1'b1;
							addr_d = {dev_hi_q, rx_byte};
							// A new word address opens a new page with nothing loaded
							mask_d = '0;
							wrote_d = 1'b0;
						end else if (at_ack) begin
							oe_d = 1'b0;
							bit_d = 4'h0;
							state_d = eeprom_pkg::ST_WDATA;
						end
					end
					eeprom_pkg::ST_WDATA: begin
						if (at_last_data) begin
							oe_d = 1'b1;
							mask_d[col] = 1'b1;
							wrote_d = 1'b1;
							addr_d = col_inc(addr_q);
						end else if (at_ack) begin
							oe_d = 1'b0;
							bit_d = 4'h0;
						end
					end
					eeprom_pkg::ST_RDATA: begin
						if (at_last_data) begin
							oe_d = 1'b0;
						end else if (at_ack) begin
							bit_d = 4'h0;
							if (nack_q) begin
								// Controller declined more data: wait for STOP quietly
								state_d = eeprom_pkg::ST_IDLE;
								oe_d = 1'b0;
							end else begin
								tx_d = mem_rd;
								addr_d = addr_inc(addr_q);
								oe_d = pull_for(mem_rd, 3'h7);
							end
						end else begin
							oe_d = pull_for(tx_q, tx_sel);
						end
					end
					default: begin
						state_d = eeprom_pkg::ST_IDLE;
						oe_d = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= eeprom_pkg::ST_IDLE;
			bit_q <= 4'h0;
			oe_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
			wrote_q <= 1'b0;
			dev_hi_q <= 3'h0;
			addr_q <= '0;
			tx_q <= 8'h00;
			mask_q <= '0;
			timer_q <= '0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			oe_q <= oe_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			wrote_q <= wrote_d;
			dev_hi_q <= dev_hi_d;
			addr_q <= addr_d;
			tx_q <= tx_d;
			mask_q <= mask_d;
			timer_q <= timer_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			// Taken from the next state, so both flags move with the state itself
			standby_q <= next_idle;
			busy_q <= next_busy;
		end
	end

	// Data storage carries no reset; only loaded columns are ever committed
	always_ff @(posedge clk) begin
		if (buf_we) begin
			page_buf[col] <= rx_byte;
		end
	end

	// One column per cycle at the start of the programming window keeps a
	// single write port on the array; the row stays fixed for the whole page
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[{addr_q[`ADDR_W-1:`COL_W], prog_col}] <= page_buf[prog_col];
		end
	end

	// The pad only ever pulls low; the high level comes from the pull-up
	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign standby = standby_q;
	assign prog_busy = busy_q;

endmodule // i2c_eeprom_write_control

// [design/eeprom_defs.svh]
// Constants shared by the serial EEPROM target logic
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Device-type field expected in the top nibble of the address byte
`define DEV_TYPE_CODE 4'ha
// Array geometry: 128 rows of 16 bytes, 11-bit word address
`define ADDR_W 11
`define MEM_DEPTH 2048
`define ROW_W 7
`define COL_W 4
`define PAGE_BYTES 16
// Clock-rise counts inside one 9-clock word
`define BIT_LAST_DATA 4'h8
`define BIT_ACK 4'h9
// Self-timed programming time, and the local clock period
`define WRITE_CYCLE_TIME_US 5000
`define CLK_PERIOD_NS 8
// Idle levels of the synchronised pins {scl, sda, wp}
`define PIN_IDLE 3'h6

`endif

// [design/eeprom_pkg.sv]
// Types shared by the serial EEPROM target logic
package eeprom_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WADDR,
		ST_WDATA,
		ST_RDATA,
		ST_BUSY
	} state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
	} pins_t;

endpackage

// [design/sync_2ff.sv]
// Two-flip-flop synchroniser for one pin level
module sync_2ff #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);

	logic meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // sync_2ff

// [design/scl_shift_in.sv]
// Link-side receive shifter clocked by the serial clock
module scl_shift_in (
	input wire logic scl,
	input wire logic rst_n,
	input wire logic sda_i,
	output logic [7:0] shift_q
);

	// Shifts on every rising serial clock; the word boundary is tracked
	// in the local domain, which reads this only while it is stable
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 8'h00;
		end else begin
			shift_q <= {shift_q[6:0], sda_i};
		end
	end

endmodule // scl_shift_in

// [verif/eeprom_port_checker.sv]
// Port checks for the two-wire EEPROM target
module eeprom_port_checker #(
	parameter int unsigned WRITE_CYCLE_CYCLES = 400
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic wp,
	input wire logic standby,
	input wire logic prog_busy
);
	// Slack only; prog_busy rises and falls from the state register, WRITE_CYCLE_CYCLES clocks apart
	localparam int LO = WRITE_CYCLE_CYCLES - 2;
	localparam int HI = WRITE_CYCLE_CYCLES + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_open_drain: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	a_reset_idle: assert property ($rose(rst_n) |-> standby && !prog_busy)
		else $error("not idle after reset");
	a_busy_not_idle: assert property (prog_busy |-> !standby)
		else $error("idle while programming");
	a_poll_nack: assert property (prog_busy |-> !sda_oe)
		else $error("drive while programming");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
		else $error("data changed with clock high");
	a_prog_time: assert property ($rose(prog_busy) |-> ##[LO:HI] $fell(prog_busy))
		else $error("programming time wrong");
	a_done_idle: assert property ($fell(prog_busy) |-> standby)
		else $error("no idle after programming");
	a_wp_block: assert property ($rose(prog_busy) |-> !$past(wp, 8))
		else $error("programming while protected");
endmodule // eeprom_port_checker

bind i2c_eeprom_write_control eeprom_port_checker #(
	.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) eeprom_port_checker_i (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .standby(standby), .prog_busy(prog_busy));

// [verif/twi_ctl.sv]
// Two-wire bus controller model; clock stands high between frames
module twi_ctl (
	input wire logic sda,
	output logic scl,
	output logic sda_drv,
	output logic rx_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	event rx_ev;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Data moves mid low phase so it never races the clock edge
	task automatic put_bit(input logic b);
		#31.25 sda_drv = b;
		#31.25 scl = 1'b1;
		rx_bit = sda;
		->rx_ev;
		#62.5 scl = 1'b0;
	endtask
	task automatic start();
		sda_drv = 1'b1;
		#31.25 scl = 1'b1;
		#31.25 sda_drv = 1'b0;
		#31.25 scl = 1'b0;
	endtask
	task automatic stop();
		#31.25 sda_drv = 1'b0;
		#31.25 scl = 1'b1;
		#31.25 sda_drv = 1'b1;
		#62.5;
	endtask
endmodule // twi_ctl

// [verif/i2c_eeprom_write_control_tb.sv]
// Self-checking bench for the two-wire EEPROM target
module i2c_eeprom_write_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wp;
	wire logic scl, sda_drv, sda_o, sda_oe, standby, prog_busy, rx_bit;
	// Pulled-up wire: low if either party pulls it down
	wire logic sda = sda_drv & ~(sda_oe & ~sda_o);
	int n_errors = 0;
	int total_checks = 0;
	logic exp_q[$];
	logic [7:0] pg[17];
	logic [7:0] b1;
	i2c_eeprom_write_control #(.WRITE_CYCLE_CYCLES(400)) i2c_eeprom_write_control_i (
		.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .wp(wp), .standby(standby), .prog_busy(prog_busy));
	twi_ctl twi_ctl_i (.sda(sda), .scl(scl), .sda_drv(sda_drv), .rx_bit(rx_bit));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %b seen %b", what, e, s);
		end
	endtask
	always @(twi_ctl_i.rx_ev) chk("sda", exp_q.pop_front(), twi_ctl_i.rx_bit);
	task automatic wr(input logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			exp_q.push_back(d[i]);
			twi_ctl_i.put_bit(d[i]);
		end
		exp_q.push_back(ack);
		twi_ctl_i.put_bit(1'b1);
	endtask
	task automatic rd(input logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) begin
			exp_q.push_back(d[i]);
			twi_ctl_i.put_bit(1'b1);
		end
		exp_q.push_back(last);
		twi_ctl_i.put_bit(last);
	endtask
	task automatic addr(input logic [10:0] a);
		twi_ctl_i.start();
		wr({4'ha, a[10:8], 1'b0}, 1'b0);
		wr(a[7:0], 1'b0);
	endtask
	task automatic settle(input logic busy);
		repeat (12) @(posedge clk);
		chk("prog_busy", busy, prog_busy);
		chk("standby", !busy, standby);
		if (busy) begin
			twi_ctl_i.start();
			wr(8'ha0, 1'b1);
			twi_ctl_i.stop();
		end
		for (int n = 0; n < 1000 && prog_busy !== 1'b0; n++) @(posedge clk);
		chk("prog_busy", 1'b0, prog_busy);
		chk("standby", 1'b1, standby);
	endtask
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		wp = 1'b0;
		b1 = 8'($urandom(32'h66be));
		foreach (pg[i]) pg[i] = 8'($urandom);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("standby", 1'b1, standby);
		addr(11'h123);
		wr(b1, 1'b0);
		twi_ctl_i.stop();
		settle(1'b1);
		addr(11'h250);
		foreach (pg[i]) wr(pg[i], 1'b0);
		twi_ctl_i.stop();
		settle(1'b1);
		twi_ctl_i.start();
		wr(8'ha1, 1'b0);
		rd(pg[1], 1'b1);
		twi_ctl_i.stop();
		twi_ctl_i.start();
		wr(8'h36, 1'b1);
		wr(8'h55, 1'b1);
		twi_ctl_i.stop();
		@(posedge clk) wp <= 1'b1;
		addr(11'h123);
		wr(~b1, 1'b0);
		twi_ctl_i.stop();
		settle(1'b0);
		addr(11'h123);
		twi_ctl_i.start();
		wr(8'ha1, 1'b0);
		rd(b1, 1'b1);
		twi_ctl_i.stop();
		settle(1'b0);
		@(posedge clk) wp <= 1'b0;
		addr(11'h250);
		twi_ctl_i.start();
		wr(8'ha1, 1'b0);
		for (int i = 0; i < 16; i++) rd(pg[i == 0 ? 16 : i], i == 15);
		twi_ctl_i.stop();
		settle(1'b0);
		summarize();
	end
endmodule // i2c_eeprom_write_control_tb
